// File: ubk_cfg.svh
// Constants for the bus cycle break comparator: register offsets, field positions, reset values.
// Assumes inclusion by the package, the comparator module and its test bench.
`ifndef UBK_CFG_SVH
`define UBK_CFG_SVH

// Register byte offsets on the AHB-Lite slave.
`define UBK_OFF_ADDR_HIGH   8'h00
`define UBK_OFF_ADDR_LOW    8'h04
`define UBK_OFF_MASK_HIGH   8'h08
`define UBK_OFF_MASK_LOW    8'h0C
`define UBK_OFF_CYCLE_SEL   8'h10

// Reset value of the four address and mask registers.
`define UBK_REG_RESET       16'h0000

// Field positions inside the cycle select register.
`define UBK_REQ_HI          7
`define UBK_REQ_LO          6
`define UBK_KIND_HI         5
`define UBK_KIND_LO         4
`define UBK_DIR_HI          3
`define UBK_DIR_LO          2
`define UBK_SIZE_HI         1
`define UBK_SIZE_LO         0
`define UBK_SEL_USED_MSB    7

// Operand size codes carried on the monitor port and in the size field.
`define UBK_SIZE_IGNORE     2'h0
`define UBK_SIZE_BYTE       2'h1
`define UBK_SIZE_WORD       2'h2
`define UBK_SIZE_LONG       2'h3

// AHB transfer type and size encodings used by the slave.
`define UBK_HTRANS_NONSEQ   2'h2
`define UBK_HTRANS_SEQ      2'h3
`define UBK_HSIZE_WORD      3'h2

`endif

// File: ubk_pkg.sv
// Types shared by the bus cycle break comparator.
// Assumes the constants header is available on the include path.
package ubk_pkg;
`include "ubk_cfg.svh"

   // Data phase state of the register slave, one-hot.
   typedef enum logic [1:0]
   {
      UBK_PH_IDLE = 2'h1,
      UBK_PH_DATA = 2'h2
   } ubk_phase_e;

   // A two-bit selector field.
   typedef logic [1:0] ubk_sel_t;
endpackage

// File: ubk_break_unit.sv
// Bus cycle break comparator: an AHB-Lite register slave plus the match logic
// that compares each monitored CPU or DMA bus cycle against a programmed break condition.
// Assumes the monitored cycle arrives synchronous to hclk as a one-cycle valid strobe,
// and that the interrupt controller samples the break request on hclk.
// The register slave answers every transfer with zero wait states and an OKAY response.
// A read returns data latched at its address phase. Software that reads a register
// straight after writing it therefore sees the old value unless one idle cycle separates them.
// Standby arrives from outside this clock's timing and is synchronised, but nothing
// in the condition registers listens to it, so holding state in standby costs no logic.
// The break request is a pulse of one clock; a controller that needs it held
// must latch it on its own side.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ubk_cfg.svh"

module ubk_break_unit
   import ubk_pkg::*;
(
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave port.
   // Only the low address byte is decoded; the rest of haddr is ignored.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Monitored bus cycle.
   // All fields are qualified by mon_valid and come from logic on hclk, so they pass no synchroniser.
   input  wire logic        mon_valid,
   input  wire logic [31:0] mon_addr,
   input  wire logic        mon_is_dma,
   input  wire logic        mon_is_fetch,
   input  wire logic        mon_is_write,
   input  wire logic [1:0]  mon_size,
   // Power state, seen only to document that it never disturbs the registers.
   input  wire logic        standby,
   // Break request toward the interrupt controller.
   output logic             break_req
);

   // Programmed break condition registers.
   logic [15:0] addr_high_q;           // Upper address half.
   logic [15:0] addr_low_q;            // Lower address half.
   logic [15:0] mask_high_q;           // Upper mask half.
   logic [15:0] mask_low_q;            // Lower mask half.
   logic [7:0]  cycle_sel_q;           // Used bits of the cycle select register.

   // Captured address phase.
   ubk_phase_e  phase_q;               // Data phase pending or not.
   logic        wr_q;                  // Captured write flag.
   logic [7:0]  off_q;                 // Captured byte offset.
   logic [31:0] rdata_q;               // Read data register.
   logic        break_q;               // Registered break request.

   // Standby comes from a pin outside this clock's timing, so it passes three flip-flops.
   // The synchronised level is only watched by the hold check; no register logic reads it,
   // which is what keeps standby from ever touching the break condition.
   logic [2:0]  standby_sync_q;        // Three-stage standby synchroniser.
   logic        standby_q;             // Standby level once stages two and three agree.
   wire         standby_agree = (standby_sync_q[2] == standby_sync_q[1]); // Last two stages agree.

   // Standby synchroniser; a change counts only once the last two stages agree.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         standby_sync_q <= 3'h0;
         standby_q      <= 1'b0;
      end
      else
      begin
         standby_sync_q <= {standby_sync_q[1:0], standby};
         if (standby_agree)
         begin
            standby_q <= standby_sync_q[2];
         end
      end
   end

   // A word access selects one register by its low address byte.
   function automatic logic hit(input logic [7:0] off, input logic [7:0] target);
      hit = (off == target);
   endfunction

   // A selector pair grants a match when the bit for the observed kind is set.
   // Code 00 therefore never matches, which is the "no break" setting.
   // Keeping the decode in one function means the three selector pairs cannot drift
   // apart in how they read their bits.
   function automatic logic pair_ok(input ubk_sel_t sel, input logic second);
      pair_ok = second ? sel[1] : sel[0];
   endfunction

   // Address phase accepted when selected, ready and a real transfer.
   wire         addr_take   = hsel && hready &&
                              (htrans == `UBK_HTRANS_NONSEQ || htrans == `UBK_HTRANS_SEQ);
   wire         in_data     = (phase_q == UBK_PH_DATA);
   wire         do_write    = in_data && wr_q;

   // Register write strobes, decoded from the captured offset.
   wire         we_addr_hi  = do_write && hit(off_q, `UBK_OFF_ADDR_HIGH);
   wire         we_addr_lo  = do_write && hit(off_q, `UBK_OFF_ADDR_LOW);
   wire         we_mask_hi  = do_write && hit(off_q, `UBK_OFF_MASK_HIGH);
   wire         we_mask_lo  = do_write && hit(off_q, `UBK_OFF_MASK_LOW);
   wire         we_sel      = do_write && hit(off_q, `UBK_OFF_CYCLE_SEL);

   // Read mux, selected by the address phase so data is ready one cycle later.
   // Unmapped offsets read zero; the reserved selection bits read zero too.
   // The mux looks at the live address bus, not the captured offset, because the
   // data must already sit in the read register when the data phase begins.
   // The price is that a write still in its data phase is not yet visible here.
   wire [7:0]   rd_off      = haddr[7:0];
   wire [31:0]  rd_mux      =
      hit(rd_off, `UBK_OFF_ADDR_HIGH) ? {16'h0000, addr_high_q} :
      hit(rd_off, `UBK_OFF_ADDR_LOW)  ? {16'h0000, addr_low_q}  :
      hit(rd_off, `UBK_OFF_MASK_HIGH) ? {16'h0000, mask_high_q} :
      hit(rd_off, `UBK_OFF_MASK_LOW)  ? {16'h0000, mask_low_q}  :
      hit(rd_off, `UBK_OFF_CYCLE_SEL) ? {24'h000000, cycle_sel_q} :
      32'h00000000;

   // Address comparison: a set mask bit removes that bit from the compare.
   // The two halves are joined so one 32-bit compare serves both register pairs.
   // An all-ones mask makes every address match.
   wire [31:0]  brk_addr    = {addr_high_q, addr_low_q};
   wire [31:0]  brk_mask    = {mask_high_q, mask_low_q};
   wire         addr_ok     = (((mon_addr ^ brk_addr) & ~brk_mask) == 32'h00000000);

   // Selector fields.
   // Requester, kind and direction are each a pair of grant bits: bit zero for the first kind of cycle
   // (CPU, fetch, read) and bit one for the second (DMA, data, write). Code 00
   // grants nothing, so any one of those three pairs left at zero silences the whole break; size code 00 ignores size.
   wire ubk_sel_t req_sel   = cycle_sel_q[`UBK_REQ_HI:`UBK_REQ_LO];
   wire ubk_sel_t kind_sel  = cycle_sel_q[`UBK_KIND_HI:`UBK_KIND_LO];
   wire ubk_sel_t dir_sel   = cycle_sel_q[`UBK_DIR_HI:`UBK_DIR_LO];
   wire ubk_sel_t size_sel  = cycle_sel_q[`UBK_SIZE_HI:`UBK_SIZE_LO];

   wire         req_ok      = pair_ok(req_sel, mon_is_dma);
   wire         kind_ok     = pair_ok(kind_sel, !mon_is_fetch);
   wire         dir_ok      = pair_ok(dir_sel, mon_is_write);

   // Fetches always compare as word; data uses its own operand size.
   // Software is expected to keep the size low bit clear for fetch breaks; if it
   // does not, a byte or long word size simply never matches a fetch.
   wire [1:0]   eff_size    = mon_is_fetch ? `UBK_SIZE_WORD : mon_size;
   wire         size_ok     = (size_sel == `UBK_SIZE_IGNORE) || (size_sel == eff_size);

   wire         cycle_match = mon_valid && addr_ok && req_ok && kind_ok && dir_ok && size_ok;

   // Slave outputs; this slave never inserts wait states and never errors.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;
   assign break_req = break_q;

   // Address phase capture and read data register.
   // Only the write flag, the offset and the read data survive into the data phase.
   // The phase register is one-hot so that an illegal code is easy to spot.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         phase_q <= UBK_PH_IDLE;
         wr_q    <= 1'b0;
         off_q   <= 8'h00;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         // Only full-word writes are decoded; reads decode at any size, and narrower writes complete but write nothing.
         phase_q <= addr_take ? UBK_PH_DATA : UBK_PH_IDLE;
         wr_q    <= addr_take && hwrite && (hsize == `UBK_HSIZE_WORD);
         off_q   <= haddr[7:0];
         if (addr_take && !hwrite)
         begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Condition registers. Standby has no term here, so it can never disturb them.
   // Writes take the low half of the data word; the upper half is dropped.
   // The select register keeps only its low byte, which also makes the reserved
   // bits cheap: there is nothing stored that could ever read back as one.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         addr_high_q <= `UBK_REG_RESET;
         addr_low_q  <= `UBK_REG_RESET;
         mask_high_q <= `UBK_REG_RESET;
         mask_low_q  <= `UBK_REG_RESET;
         cycle_sel_q <= 8'h00;
      end
      else
      begin
         if (we_addr_hi) addr_high_q <= hwdata[15:0];
         if (we_addr_lo) addr_low_q  <= hwdata[15:0];
         if (we_mask_hi) mask_high_q <= hwdata[15:0];
         if (we_mask_lo) mask_low_q  <= hwdata[15:0];
         // Reserved bits are not stored, so they always read back zero.
         if (we_sel)     cycle_sel_q <= hwdata[`UBK_SEL_USED_MSB:0];
      end
   end

   // Break request: one registered pulse for each matching monitored cycle.
   // Registering costs one cycle of latency but keeps the compare tree off the
   // interrupt controller's input timing.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         break_q <= 1'b0;
      end
      else
      begin
         break_q <= cycle_match;
      end
   end

   // Assertions.
   // They watch the registered request against the comparison terms one cycle earlier,
   // and the register file against the bus transfers that should have changed it.

   // A monitored cycle that differs from the break address in an unmasked bit.
   sequence addr_miss;
      mon_valid && (((mon_addr ^ brk_addr) & ~brk_mask) != 32'h00000000);
   endsequence

   chk_pulse_follows_match: assert property (@(posedge hclk) disable iff (!hresetn)
      cycle_match |=> break_req) else $error("Break missing after match");
   chk_no_break_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      !mon_valid |=> !break_req) else $error("Break without monitored cycle");
   chk_req_none: assert property (@(posedge hclk) disable iff (!hresetn)
      (req_sel == 2'h0) |=> !break_req) else $error("Break with requester none");
   chk_kind_none: assert property (@(posedge hclk) disable iff (!hresetn)
      (kind_sel == 2'h0) |=> !break_req) else $error("Break with access kind none");
   chk_dir_none: assert property (@(posedge hclk) disable iff (!hresetn)
      (dir_sel == 2'h0) |=> !break_req) else $error("Break with direction none");
   chk_addr_masked: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_miss |=> !break_req)
      else $error("Break on unmasked address mismatch");
   chk_fetch_word: assert property (@(posedge hclk) disable iff (!hresetn)
      (mon_valid && mon_is_fetch && size_sel == `UBK_SIZE_BYTE) |=> !break_req)
      else $error("Fetch matched as byte");
   chk_data_size: assert property (@(posedge hclk) disable iff (!hresetn)
      (mon_valid && !mon_is_fetch && size_sel != 2'h0 && size_sel != mon_size) |=> !break_req)
      else $error("Data size mismatch broke");

   // A select write, seen at the edge after its data phase has stored it.
   sequence sel_written;
      we_sel ##1 1'b1;
   endsequence

   // A read of the select register taken in its address phase.
   sequence sel_read_taken;
      addr_take && !hwrite && (rd_off == `UBK_OFF_CYCLE_SEL);
   endsequence

   // A read of any other offset taken in its address phase.
   sequence other_read_taken;
      addr_take && !hwrite && (rd_off != `UBK_OFF_CYCLE_SEL);
   endsequence

   // The stored select byte equals what the data phase carried.
   chk_sel_store: assert property (@(posedge hclk) disable iff (!hresetn)
      sel_written |-> (cycle_sel_q == $past(hwdata[7:0]))) else $error("Select write lost");

   // Once synchronised, standby with no register write in its data phase leaves every condition register as it was.
   chk_standby_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (standby_q && !do_write) |=> $stable(brk_addr) && $stable(brk_mask) && $stable(cycle_sel_q))
      else $error("Registers changed in standby");

   // Reserved select bits read back as zero.
   chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      sel_read_taken |=> (hrdata[31:8] == 24'h000000)) else $error("Reserved bits nonzero");

   // The other registers are sixteen bits wide and read zero above.
   chk_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      other_read_taken |=> (hrdata[31:16] == 16'h0000)) else $error("Upper read bits nonzero");

   // Each write lands in the register that it addresses.
   chk_addr_hi_store: assert property (@(posedge hclk) disable iff (!hresetn)
      we_addr_hi |=> (addr_high_q == $past(hwdata[15:0]))) else $error("Address high write lost");
   chk_addr_lo_store: assert property (@(posedge hclk) disable iff (!hresetn)
      we_addr_lo |=> (addr_low_q == $past(hwdata[15:0]))) else $error("Address low write lost");
   chk_mask_hi_store: assert property (@(posedge hclk) disable iff (!hresetn)
      we_mask_hi |=> (mask_high_q == $past(hwdata[15:0]))) else $error("Mask high write lost");
   chk_mask_lo_store: assert property (@(posedge hclk) disable iff (!hresetn)
      we_mask_lo |=> (mask_low_q == $past(hwdata[15:0]))) else $error("Mask low write lost");

   // Without a match in one cycle there is no request in the next.
   chk_quiet_no_match: assert property (@(posedge hclk) disable iff (!hresetn)
      !cycle_match |=> !break_req) else $error("Break without full match");

   // Read data stands until the next read is taken.
   chk_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !(addr_take && !hwrite) |=> $stable(hrdata)) else $error("Read data changed without read");

   // Every selected transfer is answered at once with OKAY.
   chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      hsel |-> (hreadyout && !hresp)) else $error("Slave stalled or errored");
endmodule

// File: ubk_mon_model.sv
// Partner model of the monitored CPU and DMA bus, plus the sampling side of the interrupt controller.
// Assumes hclk is shared with the comparator and every field changes just after a rising edge.
`timescale 1ns/1ps
module ubk_mon_model
(
   // Clock and break request as seen by the interrupt side.
   input  wire logic        hclk,
   input  wire logic        break_req,
   // Monitored bus cycle toward the comparator.
   output logic             mon_valid,
   output logic [31:0]      mon_addr,
   output logic             mon_is_dma,
   output logic             mon_is_fetch,
   output logic             mon_is_write,
   output logic [1:0]       mon_size
);
   // The bus starts idle.
   initial
   begin
      {mon_valid, mon_addr, mon_is_dma, mon_is_fetch, mon_is_write, mon_size} = '0;
   end

   // One bus cycle; k is {dma, fetch, write, size}, and hit is the request seen one cycle later.
   task automatic fire(input logic [31:0] a, input logic [4:0] k, output logic hit);
      @(posedge hclk);
      mon_valid <= 1'b1;
      {mon_addr, mon_is_dma, mon_is_fetch, mon_is_write, mon_size} <= {a, k};
      @(posedge hclk);
      mon_valid <= 1'b0;
      // Scrambled fields after the cycle, so a stale value can never match by luck.
      {mon_addr, mon_is_dma, mon_is_fetch, mon_is_write, mon_size} <= ~{a, k};
      #1 hit = break_req;
   endtask
endmodule

// File: ubk_break_unit_test.sv
// Self-checking bench for the break comparator: AHB-Lite register tasks and monitored cycles.
// Assumes a zero-wait slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`include "ubk_cfg.svh"
module ubk_break_unit_test
   import ubk_pkg::*;
();
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        standby;
   logic        break_req;
   logic        mon_valid;
   logic [31:0] mon_addr;
   logic        mon_is_dma;
   logic        mon_is_fetch;
   logic        mon_is_write;
   logic [1:0]  mon_size;
   int          err_total = 0;
   int          checks = 0;

   ubk_break_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .mon_valid(mon_valid), .mon_addr(mon_addr),
      .mon_is_dma(mon_is_dma), .mon_is_fetch(mon_is_fetch), .mon_is_write(mon_is_write),
      .mon_size(mon_size), .standby(standby), .break_req(break_req));
   ubk_mon_model i_mon (.hclk(hclk), .break_req(break_req), .mon_valid(mon_valid), .mon_addr(mon_addr),
      .mon_is_dma(mon_is_dma), .mon_is_fetch(mon_is_fetch), .mon_is_write(mon_is_write),
      .mon_size(mon_size));

   // A 100 MHz clock.
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // Counts a comparison and reports a mismatch at once.
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One single AHB-Lite transfer; the master waits on hready rather than assuming a latency.
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, `UBK_HTRANS_NONSEQ, wr, 24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      ahb(1'b1, a, d, unused);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      ahb(1'b0, a, 32'h0, v);
      cmp(v, exp);
      cmp({31'h0, hresp}, 32'h0);
   endtask

   // One monitored cycle compared with the expected break decision.
   task automatic hitc(input logic [31:0] a, input logic [4:0] k, input logic exp);
      logic h;
      i_mon.fire(a, k, h);
      cmp({31'h0, h}, {31'h0, exp});
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // The whole run needs well under a thousand cycles; this limit cuts a hang short.
   initial
   begin
      #400000;
      err_total++;
      conclude();
   end

   initial
   begin
      {hsel, htrans, hwrite, haddr, hwdata, standby} = '0;
      hsize = `UBK_HSIZE_WORD;
      hresetn = 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'h0);
      wr(`UBK_OFF_ADDR_HIGH, 32'h0012);
      wr(`UBK_OFF_ADDR_LOW, 32'h3456);
      wr(`UBK_OFF_MASK_HIGH, 32'hFFFF);
      wr(`UBK_OFF_MASK_LOW, 32'hFFFF);
      wr(`UBK_OFF_CYCLE_SEL, 32'h00FF);
      standby <= 1'b1;
      rdc(`UBK_OFF_ADDR_HIGH, 32'h0012);
      rdc(`UBK_OFF_ADDR_LOW, 32'h3456);
      rdc(`UBK_OFF_MASK_HIGH, 32'hFFFF);
      rdc(`UBK_OFF_MASK_LOW, 32'hFFFF);
      rdc(`UBK_OFF_CYCLE_SEL, 32'h00FF);
      rdc(8'h20, 32'h0);
      standby <= 1'b0;
      $display("test registers ended");
      // With every address bit masked, each selector code is walked in turn.
      for (int c = 0; c < 4; c++)
      begin
         wr(`UBK_OFF_CYCLE_SEL, {24'h0, 2'(c), 6'h3C});
         hitc(32'h0, 5'h06, c[0]);
         hitc(32'h0, 5'h16, c[1]);
         wr(`UBK_OFF_CYCLE_SEL, {24'h0, 2'h3, 2'(c), 4'hC});
         hitc(32'h0, 5'h0A, c[0]);
         hitc(32'h0, 5'h06, c[1]);
         wr(`UBK_OFF_CYCLE_SEL, {24'h0, 4'hF, 2'(c), 2'h0});
         hitc(32'h0, 5'h02, c[0]);
         hitc(32'h0, 5'h06, c[1]);
         wr(`UBK_OFF_CYCLE_SEL, {24'h0, 6'h3B, 2'(c)});
         for (int s = 1; s < 4; s++) hitc(32'h0, 5'(s), c == 0 || c == s);
         // Fetch breaks keep the size low bit clear; a byte-sized fetch still compares as a word.
         if (!c[0])
         begin
            wr(`UBK_OFF_CYCLE_SEL, {24'h0, 6'h37, 2'(c)});
            hitc(32'h0, 5'h09, 1'b1);
         end
      end
      $display("test selectors ended");
      wr(`UBK_OFF_MASK_HIGH, 32'h0);
      wr(`UBK_OFF_MASK_LOW, 32'h0);
      wr(`UBK_OFF_CYCLE_SEL, 32'h006A);
      hitc(32'h00123456, 5'h06, 1'b1);
      @(posedge hclk);
      #1 cmp({31'h0, break_req}, 32'h0);
      hitc(32'h00123457, 5'h06, 1'b0);
      hitc(32'h00133456, 5'h06, 1'b0);
      wr(`UBK_OFF_MASK_LOW, 32'h0001);
      hitc(32'h00123457, 5'h06, 1'b1);
      hitc(32'h00133456, 5'h06, 1'b0);
      wr(`UBK_OFF_MASK_HIGH, 32'h0001);
      hitc(32'h00133456, 5'h06, 1'b1);
      $display("test address ended");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(`UBK_OFF_CYCLE_SEL, 32'h0);
      rdc(`UBK_OFF_MASK_HIGH, 32'h0);
      $display("test second reset ended");
      conclude();
   end
endmodule
